// ==== verilog/fopc_cfg.svh ====
`ifndef FOPC_CFG_SVH
`define FOPC_CFG_SVH
// Functional notes
// - Select inputs captured at full-reset release
// - Partial clear keeps offsets and method
// - Preset codes load 64/16/8/256/1024 offsets
// - Code L,H,L selects serial offset loading
// - H,L,L parallel plain; L,L,L interleaved parity
// - Select2 picks parity placement for parallel
// - First two writes load Y then X
// - Plain parallel offset from low bits
// - Interleaved parallel skips data line eight
// - Serial: one bit per clock while gate low
// - Serial fills Y before X
// - Ready flag low until serial load done
// - Port A drives only when selected reading
// - Port A FIFO write decode
// - Port B drives when selected reading
// - Port B FIFO read decode
// - Read while empty ignored, output held
// - Write while full ignored, memory untouched
// - Mailbox 1: A writes, B reads, flag
// - Mailbox 2: B writes, A reads, flag

// Select codes {sel2, sel1, sel0} sampled at full-reset release
`define FOPC_SEL_P64    3'h7
`define FOPC_SEL_P16    3'h6
`define FOPC_SEL_P8     3'h5
`define FOPC_SEL_P256   3'h3
`define FOPC_SEL_P1024  3'h1
`define FOPC_SEL_SERIAL 3'h2
`define FOPC_SEL_PAR    3'h4
`define FOPC_SEL_IPAR   3'h0

// Preset offset values
`define FOPC_PRESET_64   32'h40
`define FOPC_PRESET_16   32'h10
`define FOPC_PRESET_8    32'h8
`define FOPC_PRESET_256  32'h100
`define FOPC_PRESET_1024 32'h400

// Data line ignored in interleaved-parity loading
`define FOPC_PARITY_LINE 8
// Number of parallel offset loads (Y then X)
`define FOPC_PAR_LOADS 2'h2

`endif

// ==== verilog/fopc_pkg.sv ====
package fopc_pkg;

  // Offset programming method, one-hot
  typedef enum logic [3:0] {
    FOPC_MODE_PRESET = 4'b0001,
    FOPC_MODE_SERIAL = 4'b0010,
    FOPC_MODE_PAR    = 4'b0100,
    FOPC_MODE_IPAR   = 4'b1000
  } fopc_mode_t;

endpackage : fopc_pkg

// ==== verilog/fopc_offset_port_ctrl.sv ====
`timescale 1ns/100ps
`include "fopc_cfg.svh"
module fopc_offset_port_ctrl import fopc_pkg::*; #(
  parameter int OFS_W  = 13,
  parameter int DATA_W = 36
) (
  input  wire logic              CLK_I,
  input  wire logic              SYS_RST_I,
  input  wire logic              FULL_RESET_N_I,
  input  wire logic              PARTIAL_CLEAR_N_I,
  input  wire logic              OFFSET_SEL0_SERIAL_BIT_I,
  input  wire logic              OFFSET_SEL1_SHIFT_GATE_I,
  input  wire logic              PARITY_PLACE_SEL_I,
  input  wire logic              PORT_A_CHIP_SEL_N_I,
  input  wire logic              PORT_A_DIR_SEL_I,
  input  wire logic              PORT_A_STROBE_GATE_I,
  input  wire logic              PORT_A_MAILBOX_SEL_I,
  input  wire logic [DATA_W-1:0] PORT_A_DATA_I,
  output logic      [DATA_W-1:0] PORT_A_DATA_O,
  output logic                   PORT_A_DATA_OE_O,
  input  wire logic              PORT_B_CHIP_SEL_N_I,
  input  wire logic              PORT_B_DIR_SEL_I,
  input  wire logic              PORT_B_STROBE_GATE_I,
  input  wire logic              PORT_B_MAILBOX_SEL_I,
  input  wire logic [DATA_W-1:0] PORT_B_DATA_I,
  output logic      [DATA_W-1:0] PORT_B_DATA_O,
  output logic                   PORT_B_DATA_OE_O,
  output logic                   FULL_READY_FLAG_O,
  output logic                   EMPTY_VALID_FLAG_O,
  output logic                   NEAR_EMPTY_FLAG_N_O,
  output logic                   NEAR_FULL_FLAG_N_O,
  output logic                   MAILBOX1_FULL_N_O,
  output logic                   MAILBOX2_FULL_N_O,
  output logic      [OFS_W-1:0]  ALMOST_EMPTY_OFS_O,
  output logic      [OFS_W-1:0]  ALMOST_FULL_OFS_O
);

  localparam int CNT_W = OFS_W + 1;
  localparam int SER_W = $clog2(2 * OFS_W + 1);
  localparam logic [CNT_W-1:0] DEPTH   = CNT_W'(1) << OFS_W;
  localparam logic [SER_W-1:0] SER_END = SER_W'(2 * OFS_W - 1);

  typedef struct packed {
    logic [2:0]        rst_sync;   // [0] is the first synchroniser flop
    logic [1:0]        clr_sync;
    logic [2:0]        sel_s1;
    logic [2:0]        sel_s2;
    fopc_mode_t        mode;
    logic [1:0]        par_cnt;
    logic [SER_W-1:0]  ser_cnt;
    logic              cfg_done;
    logic [OFS_W-1:0]  ofs_x;
    logic [OFS_W-1:0]  ofs_y;
    logic [OFS_W-1:0]  wr_ptr;
    logic [OFS_W-1:0]  rd_ptr;
    logic [CNT_W-1:0]  words;
    logic [DATA_W-1:0] mail1;
    logic [DATA_W-1:0] mail2;
    logic [DATA_W-1:0] a_out;
    logic [DATA_W-1:0] b_out;
    logic              a_oe;
    logic              b_oe;
    logic              full_ready;
    logic              empty_valid;
    logic              near_empty_n;
    logic              near_full_n;
    logic              mb1_n;
    logic              mb2_n;
  } fopc_state_t;

  fopc_state_t       s_reg;
  fopc_state_t       s_next;
  logic [DATA_W-1:0] mem [0:(1<<OFS_W)-1];
  logic              mem_wr;
  logic              in_reset;
  logic              rise;
  logic              clearing;
  logic              run;
  logic              fifo_wr_try;
  logic              fifo_wr;
  logic              mail1_wr;
  logic              mail2_rd;
  logic              fifo_rd_try;
  logic              fifo_rd;
  logic              mail1_rd;
  logic              mail2_wr;
  logic [OFS_W-1:0]  par_val;

  // Offset from a Port A word; interleaved mode drops line eight
  function automatic logic [OFS_W-1:0] fopc_par_offset(input logic [DATA_W-1:0] d, input logic ipar);
    logic [OFS_W-1:0] v;
    v = d[OFS_W-1:0];
    if (ipar) begin
      v = {d[OFS_W:`FOPC_PARITY_LINE+1], d[`FOPC_PARITY_LINE-1:0]};
    end
    return v;
  endfunction : fopc_par_offset

  // Level of both flags for a word count
  function automatic logic [1:0] fopc_near_flags(input logic [CNT_W-1:0] w, input logic [OFS_W-1:0] x,
                                                 input logic [OFS_W-1:0] y);
    fopc_near_flags = {~(w >= DEPTH - CNT_W'(y)), ~(w <= CNT_W'(x))};
  endfunction : fopc_near_flags

  // Reset edges come from pins, so the first stage is never decoded
  assign in_reset = ~s_reg.rst_sync[1];
  assign rise     = s_reg.rst_sync[1] & ~s_reg.rst_sync[2];
  assign clearing = ~s_reg.clr_sync[1];
  assign run      = ~in_reset & ~rise & ~clearing;

  // Port A decode
  assign fifo_wr_try = ~PORT_A_CHIP_SEL_N_I & PORT_A_DIR_SEL_I & PORT_A_STROBE_GATE_I
                       & ~PORT_A_MAILBOX_SEL_I;
  assign fifo_wr     = fifo_wr_try & s_reg.full_ready;
  assign mail1_wr    = ~PORT_A_CHIP_SEL_N_I & PORT_A_DIR_SEL_I & PORT_A_STROBE_GATE_I
                       & PORT_A_MAILBOX_SEL_I;
  assign mail2_rd    = ~PORT_A_CHIP_SEL_N_I & ~PORT_A_DIR_SEL_I & PORT_A_STROBE_GATE_I
                       & PORT_A_MAILBOX_SEL_I;

  // Port B decode; a B write with mailbox low matches nothing
  assign fifo_rd_try = ~PORT_B_CHIP_SEL_N_I & PORT_B_DIR_SEL_I & PORT_B_STROBE_GATE_I
                       & ~PORT_B_MAILBOX_SEL_I;
  assign fifo_rd     = fifo_rd_try & s_reg.empty_valid;
  assign mail1_rd    = ~PORT_B_CHIP_SEL_N_I & PORT_B_DIR_SEL_I & PORT_B_STROBE_GATE_I
                       & PORT_B_MAILBOX_SEL_I;
  assign mail2_wr    = ~PORT_B_CHIP_SEL_N_I & ~PORT_B_DIR_SEL_I & PORT_B_STROBE_GATE_I
                       & PORT_B_MAILBOX_SEL_I;

  assign par_val = fopc_par_offset(PORT_A_DATA_I, s_reg.mode == FOPC_MODE_IPAR);

  // Next-state logic for the whole block
  always_comb begin
    s_next          = s_reg;
    mem_wr          = 1'b0;
    s_next.rst_sync = {s_reg.rst_sync[1:0], FULL_RESET_N_I};
    s_next.clr_sync = {s_reg.clr_sync[0], PARTIAL_CLEAR_N_I};
    s_next.sel_s1   = {PARITY_PLACE_SEL_I, OFFSET_SEL1_SHIFT_GATE_I, OFFSET_SEL0_SERIAL_BIT_I};
    s_next.sel_s2   = s_reg.sel_s1;
    // Output enables are registered, so the bus turns one clock after the selects
    s_next.a_oe     = ~PORT_A_CHIP_SEL_N_I & ~PORT_A_DIR_SEL_I;
    s_next.b_oe     = ~PORT_B_CHIP_SEL_N_I & PORT_B_DIR_SEL_I;
    if (in_reset || clearing) begin
      // Both resets clear data path and flags; only full reset forgets setup
      s_next.wr_ptr       = '0;
      s_next.rd_ptr       = '0;
      s_next.words        = '0;
      s_next.full_ready   = 1'b0;
      s_next.empty_valid  = 1'b0;
      s_next.near_empty_n = 1'b0;
      s_next.near_full_n  = 1'b1;
      s_next.mb1_n        = 1'b1;
      s_next.mb2_n        = 1'b1;
      if (in_reset) begin
        s_next.cfg_done = 1'b0;
        s_next.par_cnt  = '0;
        s_next.ser_cnt  = '0;
      end
    end else if (rise) begin
      // Method chosen once, from the selects seen at release
      s_next.mode     = FOPC_MODE_PRESET;
      s_next.cfg_done = 1'b1;
      unique case (s_reg.sel_s2)
        `FOPC_SEL_P64: begin
          s_next.ofs_x = OFS_W'(`FOPC_PRESET_64);
        end
        `FOPC_SEL_P16: begin
          s_next.ofs_x = OFS_W'(`FOPC_PRESET_16);
        end
        `FOPC_SEL_P8: begin
          s_next.ofs_x = OFS_W'(`FOPC_PRESET_8);
        end
        `FOPC_SEL_P256: begin
          s_next.ofs_x = OFS_W'(`FOPC_PRESET_256);
        end
        `FOPC_SEL_P1024: begin
          s_next.ofs_x = OFS_W'(`FOPC_PRESET_1024);
        end
        `FOPC_SEL_SERIAL: begin
          s_next.mode     = FOPC_MODE_SERIAL;
          s_next.cfg_done = 1'b0;
        end
        `FOPC_SEL_PAR: begin
          s_next.mode     = FOPC_MODE_PAR;
          s_next.cfg_done = 1'b0;
        end
        `FOPC_SEL_IPAR: begin
          s_next.mode     = FOPC_MODE_IPAR;
          s_next.cfg_done = 1'b0;
        end
      endcase
      s_next.ofs_y = s_next.ofs_x;
    end else begin
      // Serial load: shifting the pair MSB first fills Y before X
      if (s_reg.mode == FOPC_MODE_SERIAL && !s_reg.cfg_done && !s_reg.sel_s2[1]) begin
        {s_next.ofs_y, s_next.ofs_x} = {s_reg.ofs_y[OFS_W-2:0], s_reg.ofs_x, s_reg.sel_s2[0]};
        s_next.ser_cnt = s_reg.ser_cnt + SER_W'(1);
        if (s_reg.ser_cnt == SER_END) begin
          s_next.cfg_done = 1'b1;
        end
      end
      // Parallel mode ignores sel0/sel1 from here on; offsets come from Port A writes
      if (fifo_wr) begin
        if (!s_reg.cfg_done && s_reg.par_cnt < `FOPC_PAR_LOADS) begin
          if (s_reg.par_cnt == 2'h0) begin
            s_next.ofs_y = par_val;
          end else begin
            s_next.ofs_x    = par_val;
            s_next.cfg_done = 1'b1;
          end
          s_next.par_cnt = s_reg.par_cnt + 2'h1;
        end else begin
          mem_wr        = 1'b1;
          s_next.wr_ptr = s_reg.wr_ptr + OFS_W'(1);
        end
      end
      if (fifo_rd) begin
        s_next.b_out  = mem[s_reg.rd_ptr];
        s_next.rd_ptr = s_reg.rd_ptr + OFS_W'(1);
      end else if (mail1_rd) begin
        s_next.b_out = s_reg.mail1;
      end
      if (mail2_rd) begin
        s_next.a_out = s_reg.mail2;
      end
      s_next.words = s_reg.words + CNT_W'(mem_wr) - CNT_W'(fifo_rd);
      // A new mail beats a read in the same clock, so no mail is lost
      if (mail1_wr) begin
        s_next.mail1 = PORT_A_DATA_I;
        s_next.mb1_n = 1'b0;
      end else if (mail1_rd) begin
        s_next.mb1_n = 1'b1;
      end
      if (mail2_wr) begin
        s_next.mail2 = PORT_B_DATA_I;
        s_next.mb2_n = 1'b0;
      end else if (mail2_rd) begin
        s_next.mb2_n = 1'b1;
      end
      // Ready rises the clock after programming ends; parallel modes raise it without waiting for the offset writes
      s_next.full_ready = (s_reg.cfg_done || s_reg.mode == FOPC_MODE_PAR || s_reg.mode == FOPC_MODE_IPAR)
                          && s_next.words != DEPTH;
      s_next.empty_valid = s_next.words != '0;
      {s_next.near_full_n, s_next.near_empty_n} = fopc_near_flags(s_next.words, s_next.ofs_x, s_next.ofs_y);
    end
  end

  // State register; reset value is all-constant
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      s_reg             <= '0;
      s_reg.mode        <= FOPC_MODE_PRESET;
      s_reg.near_full_n <= 1'b1;
      s_reg.mb1_n       <= 1'b1;
      s_reg.mb2_n       <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Storage has no reset; only the pointers give it meaning
  always_ff @(posedge CLK_I) begin
    if (mem_wr) begin
      mem[s_reg.wr_ptr] <= PORT_A_DATA_I;
    end
  end

  assign PORT_A_DATA_O       = s_reg.a_out;
  assign PORT_A_DATA_OE_O    = s_reg.a_oe;
  assign PORT_B_DATA_O       = s_reg.b_out;
  assign PORT_B_DATA_OE_O    = s_reg.b_oe;
  assign FULL_READY_FLAG_O   = s_reg.full_ready;
  assign EMPTY_VALID_FLAG_O  = s_reg.empty_valid;
  assign NEAR_EMPTY_FLAG_N_O = s_reg.near_empty_n;
  assign NEAR_FULL_FLAG_N_O  = s_reg.near_full_n;
  assign MAILBOX1_FULL_N_O   = s_reg.mb1_n;
  assign MAILBOX2_FULL_N_O   = s_reg.mb2_n;
  assign ALMOST_EMPTY_OFS_O  = s_reg.ofs_x;
  assign ALMOST_FULL_OFS_O   = s_reg.ofs_y;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_preset_sixty_four: assert property (rise && s_reg.sel_s2 == `FOPC_SEL_P64 |=>
      s_reg.ofs_x == OFS_W'(`FOPC_PRESET_64) && s_reg.ofs_y == OFS_W'(`FOPC_PRESET_64))
    else $error("Preset 64 not loaded");
  a_serial_select: assert property (rise && s_reg.sel_s2 == `FOPC_SEL_SERIAL |=>
      s_reg.mode == FOPC_MODE_SERIAL && !s_reg.cfg_done)
    else $error("Serial method not chosen");
  a_parity_select: assert property (rise && s_reg.sel_s2[1:0] == 2'h0 |=>
      s_reg.mode == ($past(s_reg.sel_s2[2]) ? FOPC_MODE_PAR : FOPC_MODE_IPAR))
    else $error("Parity placement wrong");
  a_clear_keeps_cfg: assert property (clearing && !in_reset && !rise |=>
      s_reg.mode == $past(s_reg.mode) && s_reg.ofs_x == $past(s_reg.ofs_x) && !s_reg.full_ready)
    else $error("Partial clear altered setup");
  a_serial_ready_low: assert property (s_reg.mode == FOPC_MODE_SERIAL && !s_reg.cfg_done |=>
      !FULL_READY_FLAG_O)
    else $error("Ready high during serial load");
  a_full_drops_write: assert property (run && fifo_wr_try && !s_reg.full_ready |=>
      s_reg.wr_ptr == $past(s_reg.wr_ptr) && s_reg.words <= $past(s_reg.words))
    else $error("Write accepted while full");
  a_empty_holds_out: assert property (run && !s_reg.empty_valid && !mail1_rd |=>
      $stable(PORT_B_DATA_O))
    else $error("Output changed on empty read");
  a_first_load_y: assert property (run && fifo_wr && s_reg.mode == FOPC_MODE_PAR && s_reg.par_cnt == 2'h0 |=>
      s_reg.ofs_y == $past(PORT_A_DATA_I[OFS_W-1:0]) && s_reg.wr_ptr == $past(s_reg.wr_ptr))
    else $error("First write did not load Y");
  a_port_a_drive: assert property (##1 PORT_A_DATA_OE_O == $past(!PORT_A_CHIP_SEL_N_I && !PORT_A_DIR_SEL_I))
    else $error("Port A enable wrong");
  a_port_b_drive: assert property (##1 PORT_B_DATA_OE_O == $past(!PORT_B_CHIP_SEL_N_I && PORT_B_DIR_SEL_I))
    else $error("Port B enable wrong");
  a_mail1_flag: assert property (run && mail1_wr |=> !MAILBOX1_FULL_N_O ##1
      (!MAILBOX1_FULL_N_O || $past(mail1_rd)))
    else $error("Mailbox 1 flag wrong");

endmodule : fopc_offset_port_ctrl

// ==== tb/fopc_b_host.sv ====
`timescale 1ns/100ps
// Port B host model: reads FIFO words or mailbox 1, writes mailbox 2
module fopc_b_host (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic        wr_i,
  input  wire logic        mbx_i,
  input  wire logic        stall_i,
  input  wire logic [35:0] wdata_i,
  output logic             cs_n_o,
  output logic             dir_o,
  output logic             strobe_o,
  output logic             mbx_o,
  output logic      [35:0] data_o
);
  initial begin
    cs_n_o = 1'b1;
    dir_o = 1'b1;
    strobe_o = 1'b0;
    mbx_o = 1'b0;
    data_o = '0;
  end
  // Controls move after the falling edge so the rising edge sees them settled
  always @(negedge clk_i) begin
    cs_n_o   <= !go_i;
    dir_o    <= !wr_i;
    strobe_o <= go_i && !stall_i;
    mbx_o    <= mbx_i;
    // Released bus shows the inverse, so a stale word never passes as fresh
    data_o   <= (go_i && wr_i) ? wdata_i : ~data_o;
  end
endmodule : fopc_b_host

// ==== tb/fopc_offset_port_ctrl_tb.sv ====
`timescale 1ns/100ps
module fopc_offset_port_ctrl_tb import fopc_pkg::*;;
  localparam int OW = 13;
  logic clk = 0, rst = 1, frst_n = 0, pclr_n = 1, s0 = 0, s1 = 0, s2 = 0;
  logic a_cs_n = 1, a_dir = 1, a_stb = 0, a_mbx = 0;
  logic b_go = 0, b_wr = 0, b_mbx = 0, b_stall = 0;
  logic [35:0] a_drv = '0, b_wdata = '0, a_o, b_o, b_hd, d;
  logic a_oe, b_oe, ffr, efv, ae_n, af_n, mb1_n, mb2_n, b_cs_n, b_dir, b_stb, b_mb;
  logic [OW-1:0] xo, yo, x, y;
  logic [25:0] bits;
  logic [2:0] codes[5] = '{3'h7, 3'h6, 3'h5, 3'h3, 3'h1};
  logic [12:0] vals[5] = '{13'h40, 13'h10, 13'h8, 13'h100, 13'h400};
  int n_fail = 0, checks_done = 0, seed = 32'h6905c1a2, i;
  logic [35:0] exp_q[$];
  logic pend = 0, miss = 0;
  logic [35:0] held;
  // Split data pins resolved: the design wins while it drives
  wire [35:0] a_bus = a_oe ? a_o : a_drv;
  wire [35:0] b_bus = b_oe ? b_o : b_hd;

  always #25 clk = ~clk;

  fopc_offset_port_ctrl #(.OFS_W(OW), .DATA_W(36)) u_fopc_offset_port_ctrl (
    .CLK_I(clk), .SYS_RST_I(rst), .FULL_RESET_N_I(frst_n), .PARTIAL_CLEAR_N_I(pclr_n),
    .OFFSET_SEL0_SERIAL_BIT_I(s0), .OFFSET_SEL1_SHIFT_GATE_I(s1), .PARITY_PLACE_SEL_I(s2),
    .PORT_A_CHIP_SEL_N_I(a_cs_n), .PORT_A_DIR_SEL_I(a_dir), .PORT_A_STROBE_GATE_I(a_stb),
    .PORT_A_MAILBOX_SEL_I(a_mbx), .PORT_A_DATA_I(a_bus), .PORT_A_DATA_O(a_o), .PORT_A_DATA_OE_O(a_oe),
    .PORT_B_CHIP_SEL_N_I(b_cs_n), .PORT_B_DIR_SEL_I(b_dir), .PORT_B_STROBE_GATE_I(b_stb),
    .PORT_B_MAILBOX_SEL_I(b_mb), .PORT_B_DATA_I(b_bus), .PORT_B_DATA_O(b_o), .PORT_B_DATA_OE_O(b_oe),
    .FULL_READY_FLAG_O(ffr), .EMPTY_VALID_FLAG_O(efv), .NEAR_EMPTY_FLAG_N_O(ae_n),
    .NEAR_FULL_FLAG_N_O(af_n), .MAILBOX1_FULL_N_O(mb1_n), .MAILBOX2_FULL_N_O(mb2_n),
    .ALMOST_EMPTY_OFS_O(xo), .ALMOST_FULL_OFS_O(yo));

  fopc_b_host u_fopc_b_host (
    .clk_i(clk), .go_i(b_go), .wr_i(b_wr), .mbx_i(b_mbx), .stall_i(b_stall), .wdata_i(b_wdata),
    .cs_n_o(b_cs_n), .dir_o(b_dir), .strobe_o(b_stb), .mbx_o(b_mb), .data_o(b_hd));

  task chk(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wrap_up;
    if (n_fail == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // Selects stay at the code level until serial shifting drives s0/s1 or the next full reset
  task full_rst(input logic [2:0] code);
    @(negedge clk);
    frst_n = 0;
    {s2, s1, s0} = code;
    repeat (6) @(negedge clk);
    frst_n = 1;
    repeat (6) @(negedge clk);
  endtask : full_rst

  // Bounded wait, since a ready flag that never rises must not hang the run
  task wait_ffr;
    for (i = 0; i < 40 && ffr !== 1'b1; i++) @(negedge clk);
  endtask : wait_ffr

  // One Port A cycle; read cycles expect mailbox 2 content
  task a_cyc(input logic dir, input logic mbx, input logic [35:0] dv);
    @(negedge clk);
    a_cs_n = 0;
    a_dir = dir;
    a_mbx = mbx;
    a_stb = 1;
    a_drv = dv;
    @(negedge clk);
    if (!dir) begin
      chk(a_o, dv);
      chk(a_oe, 1'b1);
      chk(mb2_n, 1'b1);
    end else
      chk(a_oe, 1'b0);
    a_stb = 0;
    a_cs_n = 1;
    a_dir = 1;
    a_drv = ~dv;
  endtask : a_cyc

  // One Port B host cycle, then time for the flags to settle
  task b_cmd(input logic wr, input logic mbx, input logic [35:0] dv);
    @(negedge clk);
    b_go <= 1;
    b_wr <= wr;
    b_mbx <= mbx;
    b_wdata <= dv;
    @(negedge clk);
    b_go <= 0;
    repeat (3) @(negedge clk);
  endtask : b_cmd

  // Host reads with random stalls until every noted word came out
  task drain;
    @(negedge clk);
    b_go <= 1;
    b_wr <= 0;
    b_mbx <= 0;
    for (i = 0; i < 200 && exp_q.size() > 0; i++) begin
      @(negedge clk);
      b_stall <= 1'($random(seed));
    end
    b_go <= 0;
    b_stall <= 0;
    repeat (3) @(negedge clk);
    chk(efv, 1'b0);
  endtask : drain

  // Watcher: a taken read must show the oldest note; a refused one holds the word
  always @(posedge clk) begin
    if (pend) begin
      chk(b_o, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
      chk(b_oe, 1'b1);
    end
    if (miss) chk(b_o, held);
    pend = !b_cs_n && b_dir && b_stb && (b_mb || efv === 1'b1);
    miss = !b_cs_n && b_dir && b_stb && !b_mb && efv === 1'b0;
    held = b_o;
  end

  initial begin
    #500000;
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    for (int k = 0; k < 5; k++) begin
      full_rst(codes[k]);
      wait_ffr();
      chk(yo, vals[k]);
      chk(xo, vals[k]);
    end
    // Offsets kept inside the legal range
    y = 13'(1 + {$random(seed)} % 8188);
    x = 13'(1 + {$random(seed)} % 8188);
    full_rst(3'h4);
    wait_ffr();
    a_cyc(1, 0, {23'h7fffff, y});
    chk(yo, y);
    a_cyc(1, 0, {23'h7fffff, x});
    chk(xo, x);
    chk(efv, 1'b0);
    repeat (3) begin
      d = {$random(seed), 4'($random(seed))};
      a_cyc(1, 0, d);
      exp_q.push_back(d);
    end
    chk(efv, 1'b1);
    chk({ae_n, af_n}, {x < 13'h3, 1'b1});
    drain();
    a_cyc(1, 0, 36'h123456789);
    @(negedge clk);
    pclr_n = 0;
    repeat (6) @(negedge clk);
    pclr_n = 1;
    wait_ffr();
    chk(efv, 1'b0);
    chk({xo, yo}, {x, y});
    chk({ae_n, af_n}, 2'h1);
    d = {$random(seed), 4'h5};
    a_cyc(1, 0, d);
    exp_q.push_back(d);
    chk(yo, y);
    drain();
    d = {$random(seed), 4'ha};
    a_cyc(1, 1, d);
    chk(mb1_n, 1'b0);
    exp_q.push_back(d);
    b_cmd(0, 1, 36'h0);
    chk(mb1_n, 1'b1);
    b_cmd(1, 0, 36'hfedcba987);
    chk({mb2_n, efv}, 2'h2);
    d = {$random(seed), 4'h3};
    b_cmd(1, 1, d);
    b_wr <= 0;
    chk(mb2_n, 1'b0);
    a_cyc(0, 1, d);
    full_rst(3'h0);
    wait_ffr();
    a_cyc(1, 0, {22'h0, y[12:8], 1'b1, y[7:0]});
    chk(yo, y);
    full_rst(3'h2);
    chk(ffr, 1'b0);
    // A write while ready is low must leave memory empty
    a_cyc(1, 0, d);
    chk(efv, 1'b0);
    bits = {y, x};
    for (int k = 25; k >= 0; k--) begin
      @(negedge clk);
      s1 = 0;
      s0 = bits[k];
    end
    @(negedge clk);
    s1 = 1;
    chk(ffr, 1'b0);
    wait_ffr();
    chk(ffr, 1'b1);
    chk(yo, y);
    chk(xo, x);
    wrap_up();
  end
endmodule : fopc_offset_port_ctrl_tb
